// ---- core/sent_serial_framer.sv ----
// Transmit framer: serial message in the status nibble, data nibbles, CRC
// and nibble pulse timing. Assumes TICK_I is a one-cycle tick strobe and
// all inputs are synchronous to CLK_SYS_I.
//
// Behaviour
// RQ1: Serial message goes into status nibble only while disable setting is 0.
// RQ2: After reset the sequence starts at the first message, ascends, then wraps.
// RQ3: With the disable setting 1, status bits 3 and 2 are zero.
// RQ4: Bit 3 carries six ones, two zeros, ID high, zero, ID low, zero.
// RQ5: Bit 2 carries the 6-bit CRC for six frames, then 12 data bits.
// RQ6: Each of 21 messages has its own enable bit; disabled ones are skipped.
// RQ7: With interleave set, message 01 precedes every other enabled message.
// RQ8: Message 01 sends error bits 11:0; message 23 temperature bits 15:4.
// RQ9: Constant messages read coefficient slots 17-31; ID messages send 0 & byte.
// RQ10: Constant messages send the slot's contents as read at the message's first frame.
// RQ11: Configurer keeps linearization to slots below the lowest used constant.
// RQ12: 12 or 16 bit measurement in three or four nibbles, MSB nibble first.
// RQ13: Layout selection adds counter, temperature, diagnostic or inverted nibbles.
// RQ14: Frame counter changes in every transmitted frame.
// RQ15: Inverted option sends the one's complement of the first data nibble.
// RQ16: Frame ends with a 4-bit CRC seeded with five.
// RQ17: By default the frame CRC covers data nibbles only.
// RQ18: With include-status set, status nibble enters the CRC first.
// RQ19: Serial CRC uses x^6+x^4+x^3+1 over 24 bits plus six zeros.
// RQ20: Each nibble is 5 ticks low then 7 plus value ticks high.
// RQ21: New serial message content is latched only after 18 frames complete.
// RQ22: Frame CRC uses x^4+x^3+x^2+1 over nibbles in sending order.
// RQ23: With no message enabled, status bits 3 and 2 are zero.
`timescale 1ns/10ps
`default_nettype none

module sent_serial_framer
  import sent_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic        TICK_I,
  input  wire logic        FRAME_REQ_I,
  input  wire logic        SERIAL_MSG_DISABLE_I,
  input  wire logic [20:0] SERIAL_MSG_ENABLE_MASK_I,
  input  wire logic        STATUS_INTERLEAVE_I,
  input  wire logic        CRC_INCLUDE_STATUS_I,
  input  wire logic [3:0]  DATA_LAYOUT_SEL_I,
  input  wire logic [1:0]  STATUS_BITS_I,
  input  wire logic [15:0] MEASUREMENT_I,
  input  wire logic [7:0]  TEMP_BYTE_I,
  input  wire logic [7:0]  DIAG_BYTE_I,
  input  wire logic [11:0] ERROR_REG_I,
  input  wire logic [15:0] TEMPERATURE_WORD_I,
  input  wire logic [15:0] DIE_LOT_NUMBER_I,
  input  wire logic [7:0]  DIE_X_POSITION_I,
  input  wire logic [7:0]  DIE_Y_POSITION_I,
  input  wire logic        COEFF_WR_I,
  input  wire logic [4:0]  COEFF_SLOT_I,
  input  wire logic [11:0] COEFF_DATA_I,
  output logic             TX_O,
  output logic             BUSY_O,
  output logic             FRAME_DONE_O,
  output logic [3:0]       STATUS_NIBBLE_O,
  output logic [3:0]       CRC_O,
  output logic [7:0]       SERIAL_MSG_ID_O,
  output logic [4:0]       SERIAL_FRAME_IDX_O
);

  coeff_if cif ();

  coeff_mem #(.DEPTH(COEFF_SLOTS)) u_mem (
    .clk_i (CLK_SYS_I),
    .port  (cif)
  );

  // Sequence state
  logic [4:0]  last_idx;
  logic        prev_was_err;
  logic [4:0]  frame_idx;
  logic [7:0]  cur_id;
  logic [11:0] cur_data;
  logic [5:0]  cur_crc;
  logic [11:0] frame_cnt;
  logic [20:0] other_mask;
  logic [5:0]  other_pick;
  logic        send_err;
  logic [4:0]  sel_idx;
  logic        any_en;
  logic        serial_on;
  logic        msg_start;
  logic [11:0] sel_data;
  logic [7:0]  use_id;
  logic [11:0] use_data;
  logic [5:0]  use_crc;
  logic        scn3;
  logic        scn2;
  logic [3:0]  status_nib;

  always_comb begin
    other_mask = SERIAL_MSG_ENABLE_MASK_I;
    if (STATUS_INTERLEAVE_I) begin
      other_mask[0] = 1'b0;
    end
    other_pick = find_next(other_mask, last_idx); // RQ6
    send_err   = STATUS_INTERLEAVE_I && SERIAL_MSG_ENABLE_MASK_I[0] &&
                 (!prev_was_err || !other_pick[5]); // RQ7
    sel_idx    = send_err ? IDX_ERR : other_pick[4:0];
    any_en     = |SERIAL_MSG_ENABLE_MASK_I;
    serial_on  = !SERIAL_MSG_DISABLE_I && any_en; // RQ1 RQ23
    msg_start  = serial_on && (frame_idx == 5'h00);
  end

  // Coefficient slot behind each constant message
  always_comb begin
    cif.wr_en   = COEFF_WR_I && (COEFF_SLOT_I >= COEFF_FIRST);
    cif.wr_addr = COEFF_AW'(COEFF_SLOT_I - COEFF_FIRST);
    cif.wr_data = COEFF_DATA_I;
    if (sel_idx >= IDX_OEM) begin
      cif.rd_addr = COEFF_AW'(sel_idx - OEM_SLOT_OF);
    end else begin
      cif.rd_addr = COEFF_AW'(sel_idx - 5'h01);
    end
  end

  always_comb begin
    if (sel_idx == IDX_ERR) begin
      sel_data = ERROR_REG_I; // RQ8
    end else if (sel_idx == IDX_TEMP) begin
      sel_data = TEMPERATURE_WORD_I[15:4]; // RQ8
    end else if (sel_idx == IDX_LOT_HI) begin
      sel_data = {4'h0, DIE_LOT_NUMBER_I[15:8]}; // RQ9
    end else if (sel_idx == IDX_LOT_LO) begin
      sel_data = {4'h0, DIE_LOT_NUMBER_I[7:0]}; // RQ9
    end else if (sel_idx == IDX_YPOS) begin
      sel_data = {4'h0, DIE_Y_POSITION_I};
    end else if (sel_idx == IDX_XPOS) begin
      sel_data = {4'h0, DIE_X_POSITION_I};
    end else begin
      sel_data = cif.rd_data; // RQ9 RQ10
    end
  end

  // A new message is composed only at its first frame
  always_comb begin
    use_id   = msg_start ? msg_id(sel_idx) : cur_id; // RQ21
    use_data = msg_start ? sel_data : cur_data;
    use_crc  = msg_start ? serial_crc(use_id, use_data) : cur_crc; // RQ19
  end

  // Status bit pattern over the 18 frames
  always_comb begin
    scn3 = 1'b0;
    scn2 = 1'b0;
    if (serial_on) begin
      if (frame_idx < FRM_CRC_END) begin
        scn3 = 1'b1; // RQ4
        scn2 = use_crc[3'(5'h05 - frame_idx)]; // RQ5
      end else begin
        scn2 = use_data[4'(FRM_DATA_OF - frame_idx)]; // RQ5
        if (frame_idx >= FRM_ID_HI && frame_idx < FRM_ZERO_MID) begin
          scn3 = use_id[3'(FRM_ID_HI_OF - frame_idx)]; // RQ4
        end else if (frame_idx >= FRM_ID_LO && frame_idx < FRM_LAST) begin
          scn3 = use_id[3'(FRM_ID_LO_OF - frame_idx)]; // RQ4
        end
      end
    end
    status_nib = {scn3, scn2, STATUS_BITS_I}; // RQ3
  end

  // Data nibble layout, first nibble in the top bits
  logic [23:0] data_nibs;
  logic [2:0]  nib_count;
  logic [11:0] m12;
  always_comb begin
    m12 = MEASUREMENT_I[11:0];
    nib_count = NIBS_LONG;
    case (DATA_LAYOUT_SEL_I)
      4'h1: data_nibs = {m12, TEMP_BYTE_I, frame_cnt[3:0]}; // RQ13
      4'h2: data_nibs = {m12, DIAG_BYTE_I, frame_cnt[3:0]};
      4'h3: data_nibs = {m12, frame_cnt};
      4'h4: data_nibs = {m12, frame_cnt[7:0], ~m12[11:8]}; // RQ15
      4'h5: data_nibs = {m12, ~m12};
      4'h6: begin
        data_nibs = {MEASUREMENT_I, 8'h00}; // RQ12
        nib_count = NIBS_MID;
      end
      4'h7: data_nibs = {MEASUREMENT_I, TEMP_BYTE_I[3:0], TEMP_BYTE_I[7:4]};
      4'h8: data_nibs = {MEASUREMENT_I, DIAG_BYTE_I};
      4'h9: data_nibs = {MEASUREMENT_I, frame_cnt[7:0]};
      default: begin
        data_nibs = {m12, 12'h000}; // RQ12
        nib_count = NIBS_SHORT;
      end
    endcase
  end

  // Frame CRC, augmented by one zero nibble
  logic [3:0] frame_crc;
  always_comb begin
    logic [3:0] c;
    logic [3:0] n;
    c = CRC4_SEED; // RQ16
    n = 4'h0;
    if (CRC_INCLUDE_STATUS_I) begin
      for (int b = 3; b >= 0; b--) begin
        c = {c[2:0], status_nib[b]} ^ (c[3] ? CRC4_POLY : 4'h0); // RQ18
      end
    end
    for (int k = 0; k <= DATA_NIB_MAX; k++) begin
      if (k < int'(nib_count)) begin
        n = data_nibs[23 - 4*k -: 4]; // RQ17
      end else begin
        n = 4'h0;
      end
      if (k <= int'(nib_count)) begin
        for (int b = 3; b >= 0; b--) begin
          c = {c[2:0], n[b]} ^ (c[3] ? CRC4_POLY : 4'h0); // RQ22
        end
      end
    end
    frame_crc = c;
  end

  logic accept;
  assign accept = FRAME_REQ_I && !BUSY_O;
  // Message sequencing
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      last_idx     <= IDX_LAST; // RQ2
      prev_was_err <= 1'b0;
      frame_idx    <= 5'h00;
      cur_id       <= 8'h00;
      cur_data     <= 12'h000;
      cur_crc      <= 6'h00;
    end else if (!serial_on) begin
      frame_idx <= 5'h00;
    end else if (accept) begin
      cur_id    <= use_id;
      cur_data  <= use_data;
      cur_crc   <= use_crc;
      frame_idx <= (frame_idx == FRM_LAST) ? 5'h00 : frame_idx + 5'h01;
      if (msg_start) begin
        prev_was_err <= send_err;
        if (!send_err) begin
          last_idx <= sel_idx; // RQ2
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      frame_cnt <= 12'h000;
    end else if (accept) begin
      frame_cnt <= frame_cnt + 12'h001; // RQ14
    end
  end

  // Nibble pulse generator
  tx_state_e           tx_state;
  logic [35:0]         frame_buf;
  logic [3:0]          nib_left;
  logic [5:0]          tick_left;
  logic                in_sync;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      tx_state     <= TX_IDLE;
      frame_buf    <= 36'h0;
      nib_left     <= 4'h0;
      tick_left    <= 6'h00;
      in_sync      <= 1'b0;
      TX_O         <= 1'b1;
      BUSY_O       <= 1'b0;
      FRAME_DONE_O <= 1'b0;
    end else begin
      FRAME_DONE_O <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (accept) begin
            frame_buf <= ({status_nib, data_nibs, 8'h00} |
                          (36'(frame_crc) << (28 - 4*int'(nib_count))));
            nib_left  <= 4'(nib_count) + 4'h2;
            in_sync   <= 1'b1;
            tick_left <= LOW_TICKS;
            TX_O      <= 1'b0;
            BUSY_O    <= 1'b1;
            tx_state  <= TX_LOW;
          end
        end
        TX_LOW: begin
          if (TICK_I) begin
            if (tick_left == 6'h01) begin
              TX_O      <= 1'b1;
              tick_left <= in_sync ? SYNC_HIGH
                                   : HIGH_BASE + 6'(frame_buf[35:32]); // RQ20
              tx_state  <= TX_HIGH;
            end else begin
              tick_left <= tick_left - 6'h01; // RQ20
            end
          end
        end
        TX_HIGH: begin
          if (TICK_I) begin
            if (tick_left != 6'h01) begin
              tick_left <= tick_left - 6'h01;
            end else if (nib_left == 4'h0) begin
              BUSY_O       <= 1'b0;
              FRAME_DONE_O <= 1'b1;
              tx_state     <= TX_IDLE;
            end else begin
              if (!in_sync) begin
                frame_buf <= {frame_buf[31:0], 4'h0};
              end
              in_sync   <= 1'b0;
              nib_left  <= nib_left - 4'h1;
              tick_left <= LOW_TICKS;
              TX_O      <= 1'b0;
              tx_state  <= TX_LOW;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      STATUS_NIBBLE_O    <= 4'h0;
      CRC_O              <= 4'h0;
      SERIAL_MSG_ID_O    <= 8'h00;
      SERIAL_FRAME_IDX_O <= 5'h00;
    end else if (accept) begin
      STATUS_NIBBLE_O    <= status_nib;
      CRC_O              <= frame_crc;
      SERIAL_MSG_ID_O    <= serial_on ? use_id : 8'h00;
      SERIAL_FRAME_IDX_O <= frame_idx;
    end
  end

endmodule : sent_serial_framer

`default_nettype wire

// ---- core/sent_pkg.sv ----
// Constants and decode helpers for the single-edge nibble transmit framer.
// Assumes a single synchronous clock domain; no bus, all settings are ports.
package sent_pkg;

  localparam int MSG_COUNT      = 21;
  localparam int MSG_IDX_W      = 5;
  localparam int ID_W           = 8;
  localparam int MSG_DATA_W     = 12;
  localparam int CRC6_W         = 6;
  localparam int CRC6_MSG_W     = 24;
  localparam int FRAME_IDX_W    = 5;
  localparam int NIB_W          = 4;
  localparam int DATA_NIB_MAX   = 6;
  localparam int FRAME_NIB_MAX  = 9;

  // Position of bits within the 18-frame serial message, counted from 0
  localparam logic [4:0] FRM_CRC_END  = 5'h06;
  localparam logic [4:0] FRM_ID_HI    = 5'h08;
  localparam logic [4:0] FRM_ZERO_MID = 5'h0C;
  localparam logic [4:0] FRM_ID_LO    = 5'h0D;
  localparam logic [4:0] FRM_LAST     = 5'h11;
  localparam logic [4:0] FRM_ID_HI_OF = 5'h0F;
  localparam logic [4:0] FRM_ID_LO_OF = 5'h10;
  localparam logic [4:0] FRM_DATA_OF  = 5'h11;

  localparam logic [5:0] CRC6_SEED    = 6'h15;
  localparam logic [5:0] CRC6_POLY    = 6'h19;
  localparam logic [3:0] CRC4_SEED    = 4'h5;
  localparam logic [3:0] CRC4_POLY    = 4'hD;

  localparam logic [5:0] LOW_TICKS    = 6'h05;
  localparam logic [5:0] HIGH_BASE    = 6'h07;
  localparam logic [5:0] SYNC_HIGH    = 6'h33;

  localparam int COEFF_SLOTS          = 15;
  localparam int COEFF_AW             = 4;
  localparam logic [4:0] COEFF_FIRST  = 5'h11;

  // Sorted message index of the fixed entries
  localparam logic [4:0] IDX_ERR      = 5'h00;
  localparam logic [4:0] IDX_CONST_LO = 5'h07;
  localparam logic [4:0] IDX_TEMP     = 5'h08;
  localparam logic [4:0] IDX_LOT_HI   = 5'h09;
  localparam logic [4:0] IDX_LOT_LO   = 5'h0A;
  localparam logic [4:0] IDX_YPOS     = 5'h0B;
  localparam logic [4:0] IDX_XPOS     = 5'h0C;
  localparam logic [4:0] IDX_OEM      = 5'h0D;
  localparam logic [4:0] IDX_LAST     = 5'h14;
  localparam logic [4:0] OEM_SLOT_OF  = 5'h06;

  localparam logic [2:0] NIBS_SHORT   = 3'h3;
  localparam logic [2:0] NIBS_MID     = 3'h4;
  localparam logic [2:0] NIBS_LONG    = 3'h6;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOW  = 2'b01,
    TX_HIGH = 2'b10
  } tx_state_e;

  // Message ID sent at each sorted index
  function automatic logic [7:0] msg_id(input logic [4:0] idx);
    logic [7:0] ids [0:20];
    ids = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
            8'h23, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h90, 8'h91, 8'h92,
            8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
    msg_id = (idx <= IDX_LAST) ? ids[idx] : 8'h00;
  endfunction

  // Enable-mask bit that gates each sorted index
  function automatic logic [4:0] msg_en_bit(input logic [4:0] idx);
    if (idx == IDX_ERR) begin
      msg_en_bit = 5'h00;
    end else if (idx <= IDX_CONST_LO) begin
      msg_en_bit = idx + 5'h01;
    end else if (idx == IDX_TEMP) begin
      msg_en_bit = 5'h01;
    end else begin
      msg_en_bit = idx;
    end
  endfunction

  // Next enabled sorted index after cur, wrapping; found is 0 if none
  function automatic logic [5:0] find_next(input logic [20:0] mask,
                                           input logic [4:0]  cur);
    logic [4:0] j;
    find_next = 6'h00;
    j = cur;
    for (int i = 0; i < MSG_COUNT; i++) begin
      j = (j == IDX_LAST) ? 5'h00 : j + 5'h01;
      if (!find_next[5] && mask[msg_en_bit(j)]) begin
        find_next = {1'b1, j};
      end
    end
  endfunction

  function automatic logic [5:0] crc6(input logic [CRC6_MSG_W-1:0] msg);
    logic [5:0] c;
    logic       b;
    c = CRC6_SEED;
    for (int i = CRC6_MSG_W + CRC6_W - 1; i >= 0; i--) begin
      b = (i >= CRC6_W) ? msg[i-CRC6_W] : 1'b0;
      c = {c[4:0], b} ^ (c[5] ? CRC6_POLY : 6'h00);
    end
    crc6 = c;
  endfunction

  // Frames 7 to 18 carry bit 3 and bit 2 as pairs; the CRC runs over them
  // in that sending order, so a receiver can check as it collects
  function automatic logic [5:0] serial_crc(
    input logic [ID_W-1:0]       id,
    input logic [MSG_DATA_W-1:0] data
  );
    logic [MSG_DATA_W-1:0] id_bits;
    logic [CRC6_MSG_W-1:0] msg;
    id_bits = {2'b00, id[7:4], 1'b0, id[3:0], 1'b0};
    msg = '0;
    for (int k = 0; k < MSG_DATA_W; k++) begin
      msg[2*k +: 2] = {id_bits[k], data[k]};
    end
    serial_crc = crc6(msg);
  endfunction

endpackage : sent_pkg

// ---- core/coeff_if.sv ----
// Port bundle between the framer and its coefficient slot memory.
// Assumes both ends share the framer clock.
`timescale 1ns/10ps
`default_nettype none

interface coeff_if;
  import sent_pkg::*;
  logic                  wr_en;
  logic [COEFF_AW-1:0]   wr_addr;
  logic [11:0]           wr_data;
  logic [COEFF_AW-1:0]   rd_addr;
  logic [11:0]           rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
  modport mem   (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : coeff_if

`default_nettype wire

// ---- core/coeff_mem.sv ----
// Shared coefficient slots that also hold the constant serial messages.
// Assumes one clock; read data is registered, one cycle behind the address.
`timescale 1ns/10ps
`default_nettype none

module coeff_mem
  import sent_pkg::*;
#(
  parameter int DEPTH = COEFF_SLOTS
) (
  input  wire logic clk_i,
  coeff_if.mem      port
);

  logic [11:0] slot [0:DEPTH-1];

  // No reset: contents are loaded by the configuring party
  always_ff @(posedge clk_i) begin
    if (port.wr_en) begin
      slot[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    port.rd_data <= slot[port.rd_addr];
  end

endmodule : coeff_mem

`default_nettype wire

// ---- verification/sent_framer_chk.sv ----
// Checker on the framer top ports: frame start and end, serial bits.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sent_framer_chk (
  input wire logic        CLK_SYS_I,
  input wire logic        RSTN_I,
  input wire logic        FRAME_REQ_I,
  input wire logic        SERIAL_MSG_DISABLE_I,
  input wire logic [20:0] SERIAL_MSG_ENABLE_MASK_I,
  input wire logic        STATUS_INTERLEAVE_I,
  input wire logic        TX_O,
  input wire logic        BUSY_O,
  input wire logic        FRAME_DONE_O,
  input wire logic [3:0]  STATUS_NIBBLE_O,
  input wire logic [7:0]  SERIAL_MSG_ID_O,
  input wire logic [4:0]  SERIAL_FRAME_IDX_O
);
  logic       busy_q;
  logic       start;
  logic       ser;
  logic [7:0] last_id;
  logic [4:0] last_idx;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  assign start = BUSY_O && !busy_q;
  assign ser   = start && SERIAL_MSG_ID_O != 8'h00;
  // Last accepted frame, for the continuity checks
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      busy_q   <= 1'b0;
      last_id  <= 8'h00;
      last_idx <= 5'h00;
    end else begin
      busy_q <= BUSY_O;
      if (start) begin
        last_id  <= SERIAL_MSG_ID_O;
        last_idx <= SERIAL_FRAME_IDX_O;
      end
    end
  end
  AST_ACCEPT: assert property (FRAME_REQ_I && !BUSY_O |=>
    (BUSY_O && !TX_O) [*2]) else $error("frame start not seen");
  AST_DONE_ONE: assert property (FRAME_DONE_O |=>
    !FRAME_DONE_O && (!BUSY_O || $past(FRAME_REQ_I)))
    else $error("done not a single pulse");
  AST_DONE_END: assert property ($fell(BUSY_O) |->
    FRAME_DONE_O && TX_O) else $error("frame end without done");
  AST_DIS_ZERO: assert property (start && SERIAL_MSG_DISABLE_I |->
    STATUS_NIBBLE_O[3:2] == 2'b00) else $error("serial bits while off");
  AST_EMPTY: assert property (start && !(|SERIAL_MSG_ENABLE_MASK_I) |->
    STATUS_NIBBLE_O[3:2] == 2'b00) else $error("serial bits, empty mask");
  AST_MARK: assert property (ser && SERIAL_FRAME_IDX_O < 5'h06 |->
    STATUS_NIBBLE_O[3]) else $error("start mark bit missing");
  AST_GAP: assert property (ser &&
    SERIAL_FRAME_IDX_O inside {5'h06, 5'h07, 5'h0C, 5'h11} |->
    !STATUS_NIBBLE_O[3]) else $error("gap bit not zero");
  AST_ID_HI: assert property (ser &&
    SERIAL_FRAME_IDX_O inside {[5'h08:5'h0B]} |-> STATUS_NIBBLE_O[3] ==
    SERIAL_MSG_ID_O[5'h0F - SERIAL_FRAME_IDX_O]) else $error("id high bad");
  AST_ID_LO: assert property (ser &&
    SERIAL_FRAME_IDX_O inside {[5'h0D:5'h10]} |-> STATUS_NIBBLE_O[3] ==
    SERIAL_MSG_ID_O[5'h10 - SERIAL_FRAME_IDX_O]) else $error("id low bad");
  AST_HOLD: assert property (ser && SERIAL_FRAME_IDX_O != 5'h00 |->
    SERIAL_MSG_ID_O == last_id && SERIAL_FRAME_IDX_O == last_idx + 5'h01)
    else $error("message changed inside its frames");
  AST_ALT: assert property (ser && SERIAL_FRAME_IDX_O == 5'h00 &&
    STATUS_INTERLEAVE_I && SERIAL_MSG_ENABLE_MASK_I[0] && last_id != 8'h01
    |-> SERIAL_MSG_ID_O == 8'h01) else $error("status message skipped");
endmodule // sent_framer_chk
bind sent_serial_framer sent_framer_chk u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .FRAME_REQ_I(FRAME_REQ_I),
  .SERIAL_MSG_DISABLE_I(SERIAL_MSG_DISABLE_I),
  .SERIAL_MSG_ENABLE_MASK_I(SERIAL_MSG_ENABLE_MASK_I),
  .STATUS_INTERLEAVE_I(STATUS_INTERLEAVE_I), .TX_O(TX_O), .BUSY_O(BUSY_O),
  .FRAME_DONE_O(FRAME_DONE_O), .STATUS_NIBBLE_O(STATUS_NIBBLE_O),
  .SERIAL_MSG_ID_O(SERIAL_MSG_ID_O), .SERIAL_FRAME_IDX_O(SERIAL_FRAME_IDX_O)
);
`default_nettype wire

// ---- verification/sent_rx_model.sv ----
// Receiver model: times each fall-to-fall interval of the line in ticks.
// Assumes it shares the tick strobe with the framer; done closes a frame.
`timescale 1ns/10ps
`default_nettype none
module sent_rx_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       tick_i,
  input  wire logic       line_i,
  input  wire logic       done_i,
  output logic [8:0][7:0] len_o,
  output logic [3:0]      n_o,
  output logic            got_o
);
  logic       line_q;
  logic [7:0] ticks;
  logic [3:0] pos;
  always_ff @(posedge clk_i) begin
    got_o <= 1'b0;
    if (!rstn_i) begin
      line_q <= 1'b1;
      ticks  <= 8'h00;
      pos    <= 4'h0;
      n_o    <= 4'h0;
    end else begin
      line_q <= line_i;
      ticks  <= ticks + {7'h00, tick_i};
      // A tick seen on the edge of the fall already belongs to the new nibble
      if (line_q && !line_i) begin
        ticks <= {7'h00, tick_i};
        pos   <= pos + 4'h1;
        if (pos != 4'h0) len_o[pos - 4'h1] <= ticks;
      end
      if (done_i) begin
        len_o[pos - 4'h1] <= ticks;
        n_o   <= pos;
        pos   <= 4'h0;
        got_o <= 1'b1;
      end
    end
  end
endmodule // sent_rx_model
`default_nettype wire

// ---- verification/sent_serial_msg_and_crc_tb.sv ----
// Bench for the framer: frames are requested one by one, decoded by the
// receiver model and compared. Assumes the core package is compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; \
  $display("mismatch %s exp %0h seen %0h", nm, e, s); end end
module sent_serial_msg_and_crc_tb;
  import sent_pkg::*;
  localparam logic [15:0] TW = 16'h7F35, LOT = 16'hC47A;
  localparam logic [7:0]  DG = 8'hE1, XP = 8'h3B, YP = 8'h92;
  logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, req = 1'b0, dis = 1'b0;
  logic il = 1'b0, cinc = 1'b0, cwr = 1'b0, got, tx, busy, done;
  logic [20:0] mask = 21'h0;
  logic [3:0]  sel = 4'h0, n, st, crc_o, st_o;
  logic [1:0]  sb = 2'h0;
  logic [15:0] meas = 16'h8421;
  logic [7:0]  tb8 = 8'h6D, id_o;
  logic [11:0] err = 12'hA5C, cdat = 12'h0, cv, pcv, mx;
  logic [4:0]  cslot = 5'h0, idx_o;
  logic [8:0][7:0] len;
  logic [23:0] sv, ev, cm;
  int errors = 0, checks_done = 0, nd;
  always #20 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  sent_serial_framer u_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .TICK_I(tick),
    .FRAME_REQ_I(req), .SERIAL_MSG_DISABLE_I(dis),
    .SERIAL_MSG_ENABLE_MASK_I(mask), .STATUS_INTERLEAVE_I(il),
    .CRC_INCLUDE_STATUS_I(cinc), .DATA_LAYOUT_SEL_I(sel),
    .STATUS_BITS_I(sb), .MEASUREMENT_I(meas), .TEMP_BYTE_I(tb8),
    .DIAG_BYTE_I(DG), .ERROR_REG_I(err), .TEMPERATURE_WORD_I(TW),
    .DIE_LOT_NUMBER_I(LOT), .DIE_X_POSITION_I(XP), .DIE_Y_POSITION_I(YP),
    .COEFF_WR_I(cwr), .COEFF_SLOT_I(cslot), .COEFF_DATA_I(cdat),
    .TX_O(tx), .BUSY_O(busy), .FRAME_DONE_O(done), .STATUS_NIBBLE_O(st_o),
    .CRC_O(crc_o), .SERIAL_MSG_ID_O(id_o), .SERIAL_FRAME_IDX_O(idx_o));
  sent_rx_model u_rx (.clk_i(clk), .rstn_i(rstn), .tick_i(tick),
    .line_i(tx), .done_i(done), .len_o(len), .n_o(n), .got_o(got));
  function automatic logic [5:0] crc6(input logic [23:0] m);
    logic [5:0] c;
    logic [29:0] v;
    c = 6'h15;
    v = {m, 6'h00};
    for (int i = 29; i >= 0; i--) c = {c[4:0], v[i]} ^ (c[5] ? 6'h19 : 6'h0);
    return c;
  endfunction
  // Nibbles are shifted in MSB first, then one zero nibble flushes the sum
  function automatic logic [3:0] crc4(input logic [27:0] v, input int nb);
    logic [3:0] c;
    c = 4'h5;
    for (int i = nb * 4 + 3; i >= 0; i--)
      c = {c[2:0], (i >= 4) ? v[i - 4] : 1'b0} ^ (c[3] ? 4'hD : 4'h0);
    return c;
  endfunction
  task automatic results();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic coeff(input logic [4:0] s, input logic [11:0] d);
    @(posedge clk);
    cwr   <= 1'b1;
    cslot <= s;
    cdat  <= d;
    @(posedge clk);
    cwr <= 1'b0;
  endtask
  task automatic frame();
    int i;
    @(posedge clk);
    meas <= meas + 16'h1357;
    tb8  <= tb8 + 8'h1D;
    sb   <= sb + 2'h1;
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    for (i = 0; i < 2000 && got !== 1'b1; i++) @(negedge clk);
    if (i >= 2000) begin
      errors++;
      results();
    end
    @(posedge clk);
    nd = 6;
    cm = 24'h0;
    case (sel)
      4'h1: begin ev = {meas[11:0], tb8, 4'h0}; cm = 24'h00000F; end
      4'h2: begin ev = {meas[11:0], DG, 4'h0}; cm = 24'h00000F; end
      4'h3: begin ev = {meas[11:0], 12'h0}; cm = 24'h000FFF; end
      4'h4: begin ev = {meas[11:0], 8'h0, ~meas[11:8]}; cm = 24'h000FF0; end
      4'h5: ev = {meas[11:0], ~meas[11:0]};
      4'h6: begin nd = 4; ev = {meas, 8'h0}; end
      4'h7: ev = {meas, tb8[3:0], tb8[7:4]};
      4'h8: ev = {meas, DG};
      4'h9: begin ev = {meas, 8'h0}; cm = 24'h0000FF; end
      default: begin nd = 3; ev = {meas[11:0], 12'h0}; end
    endcase
    st = len[1][3:0] - 4'hC;
    sv = 24'h0;
    for (int k = 0; k < nd; k++) sv[23 - 4 * k -: 4] = len[k + 2][3:0] - 4'hC;
    pcv = cv;
    cv = 12'h0;
    for (int b = 23; b >= 0; b--) if (cm[b]) cv = {cv[10:0], sv[b]};
    `CHK("sync", 8'd56, len[0])
    `CHK("nibbles", 4'(nd + 3), n)
    `CHK("data", ev, sv & ~cm)
    `CHK("status", st, st_o)
    `CHK("status_low", sb, st[1:0])
    `CHK("crc", crc4({st, sv} >> (4 * (6 - nd)), nd + int'(cinc)),
      len[nd + 2][3:0] - 4'hC)
    `CHK("crc_o", crc4({st, sv} >> (4 * (6 - nd)), nd + int'(cinc)),
      crc_o)
  endtask
  task automatic smsg(input logic [7:0] id, input logic [11:0] dt);
    logic [11:0] lo;
    logic [23:0] m;
    logic [17:0] b3, b2;
    lo = {2'b00, id[7:4], 1'b0, id[3:0], 1'b0};
    for (int k = 0; k < 12; k++) m[2 * k +: 2] = {lo[k], dt[k]};
    b3 = {6'h3F, lo};
    b2 = {crc6(m), dt};
    for (int f = 0; f < 18; f++) begin
      // Source changes mid-message must not reach this message
      if (f == 3) err <= err ^ 12'hFFF;
      frame();
      `CHK("msg_id", id, id_o)
      `CHK("frame_idx", 5'(f), idx_o)
      `CHK("bit3", b3[17 - f], st[3])
      `CHK("bit2", b2[17 - f], st[2])
    end
  endtask
  initial begin
    mask <= 21'h000207;
    do_reset();
    coeff(5'h11, 12'h3C5);
    coeff(5'h14, 12'h1E7);
    smsg(8'h01, err);
    smsg(8'h03, 12'h3C5);
    smsg(8'h23, TW[15:4]);
    smsg(8'h29, {4'h0, LOT[15:8]});
    smsg(8'h01, err);
    coeff(5'h11, 12'h6A9);
    mask <= 21'h000025;
    il   <= 1'b1;
    do_reset();
    smsg(8'h01, err);
    smsg(8'h03, 12'h6A9);
    smsg(8'h01, err);
    smsg(8'h07, 12'h1E7);
    mask <= 21'h0;
    il   <= 1'b0;
    cinc <= 1'b1;
    do_reset();
    frame();
    `CHK("empty", 2'b00, st[3:2])
    dis <= 1'b1;
    for (int s = 0; s < 10; s++) begin
      for (int r = 0; r < 2; r++) begin
        sel <= 4'(s);
        frame();
        `CHK("off", 2'b00, st[3:2])
        mx = (12'h1 << $countones(cm)) - 12'h1;
        if (r == 1 && cm != 24'h0) `CHK("count", 12'h1, (cv - pcv) & mx)
      end
    end
    results();
  end
endmodule // sent_serial_msg_and_crc_tb
`default_nettype wire
